// file: verilog/fsc_pkg.sv
`default_nettype none
package fsc_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned IMG_W = 24;
  localparam int unsigned CRC_W = 6;
  localparam logic [1:0] FAULT_CAPTURE_OFFSET = 2'h1;
  localparam logic [1:0] CONFIG_OFFSET = 2'h0;
  localparam int unsigned OC_MSB = 23;
  localparam int unsigned OC_LSB = 16;
  localparam int unsigned OS_MSB = 15;
  localparam int unsigned OS_LSB = 8;
  localparam int unsigned RSV_BIT = 7;
  localparam int unsigned TSD_BIT = 6;
  localparam int unsigned CRC_MSB = 5;
  localparam int unsigned CRC_LSB = 0;
  localparam logic [6:0] CRC_POLY = 7'h43;
  localparam logic [IMG_W-1:0] FAULT_RESET = 24'h000000;
  localparam int unsigned SYNC_STAGES = 3;

  typedef struct packed {
    logic [7:0] overcurrent;
    logic [7:0] open_short;
    logic reserved_bit;
    logic thermal_shutdown;
    logic [5:0] crc;
  } fsc_image_s;

  typedef struct packed {
    logic [7:0] overcurrent;
    logic [7:0] current_low;
    logic thermal;
  } fsc_sense_s;
endpackage : fsc_pkg
`default_nettype wire

// file: verilog/fsc_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_edge_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  import fsc_pkg::*;

  logic [SYNC_STAGES-1:0] stage;
  logic level;
  logic rise;
  logic fall;
  logic [SYNC_STAGES-1:0] next_stage;
  logic next_level;
  logic next_rise;
  logic next_fall;

  // level moves only when the second and third stage agree
  always_comb begin
    next_stage = {stage[SYNC_STAGES-2:0], pin_i};
    next_level = level;
    next_rise = 1'b0;
    next_fall = 1'b0;
    if ((stage[1] == stage[2]) && (stage[2] != level)) begin
      next_level = stage[2];
      next_rise = stage[2];
      next_fall = ~stage[2];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stage <= '0;
      level <= 1'b0;
      rise <= 1'b0;
      fall <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
      rise <= next_rise;
      fall <= next_fall;
    end
  end

  assign rise_o = rise;
  assign fall_o = fall;
endmodule : fsc_edge_sync
`default_nettype wire

// file: verilog/fsc_fault_capture.sv
//
// Contract
// - bits 23..16 hold one overcurrent flag per channel, channel seven in bit 23.
// - overcurrent flags clear when read and return only if the fault recurs.
// - bits 15..8 hold one open-load or short-to-ground flag per channel, channel seven in 15.
// - open-load or short flags clear when read.
// - bit 6 is a thermal shutdown flag that clears when read.
// - bits 5..0 carry a read-only checksum of the channel configuration, untouched by reads.
// - the fault image sits at offset 1 and resets to all zeros.
// - the checksum is the remainder of config with six zeros appended, divided by 0x43.
// - a latch clock rising edge loads the 24-bit image, bit 23 appearing at once.
// - each shift clock falling edge moves one further bit out; the host gives 23 edges.
// - an open-load flag sets only while the channel is on and current is low, no auto-off.
`timescale 1ns/100ps
`default_nettype none
module fsc_fault_capture #(
  parameter int unsigned CHANNELS = 8
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic SERIAL_SHIFT_CLOCK_I,
  input wire logic REGISTER_LATCH_CLOCK_I,
  input wire logic [7:0] CHANNEL_CONFIG_I,
  input wire fsc_pkg::fsc_sense_s SENSE_I,
  output logic SERIAL_OUT_O,
  output fsc_pkg::fsc_image_s FAULT_IMAGE_O
);
  import fsc_pkg::*;

  if (CHANNELS != NUM_CH) begin : g_check
    $error("fault image layout serves exactly eight channels");
  end

  if (IMG_W != (2 * CHANNELS) + 2 + CRC_W) begin : g_width
    $error("fault image width does not match the channel count");
  end

  // remainder of {cfg, 6'b0} divided by the polynomial
  function automatic logic [CRC_W-1:0] crc6(input logic [7:0] cfg);
    logic [13:0] work;
    work = {cfg, 6'h00};
    for (int i = 13; i >= 6; i--) begin
      if (work[i]) begin
        work[i -: 7] = work[i -: 7] ^ CRC_POLY;
      end
    end
    return work[CRC_W-1:0];
  endfunction : crc6

  logic shift_fall;
  logic latch_rise;
  fsc_image_s image;
  fsc_image_s next_image;
  logic [IMG_W-1:0] chain;
  logic [IMG_W-1:0] next_chain;
  logic [7:0] os_cause;

  fsc_edge_sync u_shift_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .pin_i(SERIAL_SHIFT_CLOCK_I),
    .rise_o(),
    .fall_o(shift_fall)
  );

  fsc_edge_sync u_latch_sync (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .pin_i(REGISTER_LATCH_CLOCK_I),
    .rise_o(latch_rise),
    .fall_o()
  );

  // open-load only counts on switched-on channels
  assign os_cause = CHANNEL_CONFIG_I & SENSE_I.current_low;

  // sticky flags: capture clears, a live fault sets and wins
  always_comb begin
    next_image = image;
    if (latch_rise) begin
      next_image.overcurrent = '0;
      next_image.open_short = '0;
      next_image.thermal_shutdown = 1'b0;
    end
    next_image.overcurrent = next_image.overcurrent | SENSE_I.overcurrent;
    next_image.open_short = next_image.open_short | os_cause;
    next_image.thermal_shutdown = next_image.thermal_shutdown | SENSE_I.thermal;
    next_image.reserved_bit = 1'b0;
    next_image.crc = crc6(CHANNEL_CONFIG_I);
  end

  // shift chain: latch wins over a coincident shift
  always_comb begin
    next_chain = chain;
    if (latch_rise) begin
      next_chain = image;
    end else if (shift_fall) begin
      next_chain = {chain[IMG_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      image <= FAULT_RESET;
    end else begin
      image <= next_image;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      chain <= FAULT_RESET;
    end else begin
      chain <= next_chain;
    end
  end

  assign SERIAL_OUT_O = chain[IMG_W-1];
  assign FAULT_IMAGE_O = image;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  a_oc_set: assert property (
    (SENSE_I.overcurrent != '0) |=>
      ((image.overcurrent & $past(SENSE_I.overcurrent)) == $past(SENSE_I.overcurrent)))
    else $error("overcurrent not flagged");

  a_oc_clear: assert property (
    (latch_rise && SENSE_I.overcurrent == '0) |=> (image.overcurrent == '0))
    else $error("overcurrent not cleared by capture");

  a_os_set: assert property (
    (os_cause != '0) |=> ((image.open_short & $past(os_cause)) == $past(os_cause)))
    else $error("open-load not flagged");

  a_os_clear: assert property (
    (latch_rise && os_cause == '0) |=> (image.open_short == '0))
    else $error("open-load not cleared by capture");

  a_os_gated: assert property (
    1'b1 |=> ((image.open_short & ~$past(image.open_short) & ~$past(os_cause)) == '0))
    else $error("open-load set without cause");

  a_tsd_flag: assert property (
    (SENSE_I.thermal |=> image.thermal_shutdown) and
    ((latch_rise && !SENSE_I.thermal) |=> !image.thermal_shutdown))
    else $error("thermal flag wrong");

  a_crc_value: assert property (
    $stable(CHANNEL_CONFIG_I) [*2] |-> (image.crc == crc6(CHANNEL_CONFIG_I)))
    else $error("checksum mismatch");

  a_reset_zero: assert property (
    $rose(NRST_I) |-> (image == FAULT_RESET && chain == FAULT_RESET))
    else $error("image not zero after reset");

  a_latch_load: assert property (
    latch_rise |=>
      (chain == $past(image) && SERIAL_OUT_O == $past(image.overcurrent[NUM_CH-1])))
    else $error("latch did not load chain");

  a_out_stable: assert property (
    (!latch_rise && !shift_fall) |=> $stable(SERIAL_OUT_O))
    else $error("serial output moved without an edge");

  a_shift_out: assert property (
    (shift_fall && !latch_rise) |=> (SERIAL_OUT_O == $past(chain[IMG_W-2])))
    else $error("serial output did not take the next bit");

  a_chain_hold: assert property (
    (!latch_rise && !shift_fall) |=> (chain == $past(chain)))
    else $error("shift chain moved without an edge");

  a_oc_hold: assert property (
    !latch_rise |=>
      ((image.overcurrent & $past(image.overcurrent)) == $past(image.overcurrent)))
    else $error("overcurrent flag dropped without capture");

  a_os_hold: assert property (
    !latch_rise |=>
      ((image.open_short & $past(image.open_short)) == $past(image.open_short)))
    else $error("open-load flag dropped without capture");

  a_tsd_hold: assert property (
    (!latch_rise && image.thermal_shutdown) |=> image.thermal_shutdown)
    else $error("thermal flag dropped without capture");

  a_oc_gated: assert property (
    1'b1 |=> ((image.overcurrent & ~$past(image.overcurrent)
      & ~$past(SENSE_I.overcurrent)) == '0))
    else $error("overcurrent set without cause");

  a_tsd_gated: assert property (
    1'b1 |=> (!image.thermal_shutdown || $past(image.thermal_shutdown)
      || $past(SENSE_I.thermal)))
    else $error("thermal flag set without cause");

  a_os_off_chan: assert property (
    1'b1 |=> ((image.open_short & ~$past(image.open_short)
      & ~$past(CHANNEL_CONFIG_I)) == '0))
    else $error("open-load set on a switched-off channel");

  a_crc_kept: assert property (
    (latch_rise && $stable(CHANNEL_CONFIG_I)) |=> (image.crc == $past(image.crc)))
    else $error("checksum altered by capture");

  a_shift_step: assert property (
    (shift_fall && !latch_rise) |=> (chain == {$past(chain[IMG_W-2:0]), 1'b0}))
    else $error("shift did not advance");

  a_set_wins: assert property (
    (latch_rise && SENSE_I.thermal) |=> image.thermal_shutdown)
    else $error("live fault lost at capture");

  c_latch: cover property (latch_rise ##[1:40] shift_fall);
  c_oc_capture: cover property ((image.overcurrent != '0) ##1 latch_rise);
  c_os_flag: cover property (os_cause != '0);
  c_tsd_capture: cover property (image.thermal_shutdown ##1 latch_rise);
  c_set_wins: cover property (latch_rise && (SENSE_I.overcurrent != '0));
endmodule : fsc_fault_capture
`default_nettype wire

// file: verilog/fsc_dummy_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: sim/fsc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsc_host_model (
  input wire logic start_i,
  input wire logic ser_i,
  output logic sck_o,
  output logic lck_o,
  output logic [23:0] word_o,
  output logic done_o
);
  initial begin
    sck_o = 1'b0;
    lck_o = 1'b0;
    done_o = 1'b0;
    word_o = 24'h000000;
  end
  // latch, then 23 falls; shift clock idles low
  always @(posedge start_i) begin
    lck_o = 1'b1;
    #320;
    word_o[23] = ser_i;
    lck_o = 1'b0;
    for (int i = 22; i >= 0; i--) begin
      sck_o = 1'b1;
      #80;
      if (i != 22) word_o[i+1] = ser_i;
      #80;
      sck_o = 1'b0;
      #160;
    end
    #80;
    word_o[0] = ser_i;
    done_o = 1'b1;
    #40;
    done_o = 1'b0;
  end
endmodule : fsc_host_model
`default_nettype wire

// file: sim/fault_status_capture_tb.sv
`timescale 1ns/100ps
`default_nettype none
module fault_status_capture_tb;
  import fsc_pkg::*;
  logic CLK_I, NRST_I, start, ser, sck, lck, done;
  logic [7:0] cfg;
  fsc_sense_s sense;
  fsc_image_s img;
  logic [23:0] word;
  logic [23:0] exp_q[$];
  logic [23:0] img_q[$];
  event img_ev;
  logic [31:0] lf = 32'hd76b;
  int n_fail = 0;
  int checks = 0;
  fsc_fault_capture i_dut (.CLK_I(CLK_I), .NRST_I(NRST_I), .SERIAL_SHIFT_CLOCK_I(sck),
    .REGISTER_LATCH_CLOCK_I(lck), .CHANNEL_CONFIG_I(cfg), .SENSE_I(sense),
    .SERIAL_OUT_O(ser), .FAULT_IMAGE_O(img));
  fsc_host_model i_host (.start_i(start), .ser_i(ser), .sck_o(sck), .lck_o(lck),
    .word_o(word), .done_o(done));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [5:0] crc6(input logic [7:0] c);
    logic [13:0] r;
    r = {c, 6'h00};
    for (int b = 13; b >= 6; b--) if (r[b]) r[b -: 7] ^= 7'h43;
    return r[5:0];
  endfunction : crc6
  task automatic wrap_up();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic tick();
    @(posedge CLK_I);
    #2;
  endtask : tick
  task automatic frame(input logic [23:0] e);
    exp_q.push_back(e);
    tick();
    start = 1'b1;
    tick();
    start = 1'b0;
    @(negedge done);
  endtask : frame
  task automatic note_img(input logic [23:0] e);
    img_q.push_back(e);
    -> img_ev;
  endtask : note_img
  always @(img_ev) begin
    checks++;
    if (img !== img_q[0]) begin
      n_fail++;
      $display("BAD fault image expected %h seen %h", img_q[0], img);
    end
    void'(img_q.pop_front());
  end
  always @(posedge done) begin
    checks++;
    if (word !== exp_q[0]) begin
      n_fail++;
      $display("BAD serial frame expected %h seen %h", exp_q[0], word);
    end
    void'(exp_q.pop_front());
  end
  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
  initial begin
    NRST_I = 1'b0;
    start = 1'b0;
    cfg = 8'h00;
    sense = '0;
    repeat (16) tick();
    NRST_I = 1'b1;
    repeat (8) tick();
    frame(24'h000000);
    cfg = 8'hff;
    frame(24'h00000d);
    for (int k = 0; k < 6; k++) begin
      repeat (8) lf = lfsr(lf);
      cfg = lf[23:16];
      tick();
      sense = {lf[7:0], lf[15:8], k[0]};
      tick();
      sense = '0;
      note_img({lf[7:0], lf[15:8] & cfg, 1'b0, k[0], crc6(cfg)});
      frame({lf[7:0], lf[15:8] & cfg, 1'b0, k[0], crc6(cfg)});
      frame({18'h0, crc6(cfg)});
    end
    sense.overcurrent = 8'h81;
    frame({8'h81, 10'h0, crc6(cfg)});
    frame({8'h81, 10'h0, crc6(cfg)});
    sense = '0;
    frame({8'h81, 10'h0, crc6(cfg)});
    frame({18'h0, crc6(cfg)});
    sense = {8'hff, 8'hff, 1'b1};
    tick();
    NRST_I = 1'b0;
    sense = '0;
    repeat (2) tick();
    note_img(24'h000000);
    NRST_I = 1'b1;
    repeat (8) tick();
    frame({18'h0, crc6(cfg)});
    wrap_up();
  end
endmodule : fault_status_capture_tb
`default_nettype wire
